// [hdl/dcpd_pkg.sv]
package dcpd_pkg;
    localparam int ROW_W    = 15;
    localparam int COL_W    = 10;
    localparam int BANK_W   = 3;
    localparam int NBANK    = 8;
    localparam int DQ_W     = 16;
    localparam int LANE_W   = 8;
    localparam int NLANE    = 2;
    localparam int BL_FULL  = 8;
    localparam int BL_CHOP  = 4;
    localparam int AP_BIT   = 10;
    localparam int BC_BIT   = 12;
    localparam int CNT_W    = 4;
    // Mode op-code fields held by the device
    localparam int MR_ODT_LO = 0;
    localparam int MR_ODT_HI = 2;
    // Controller divider: half period of the link clock in clk_sys cycles
    localparam int CK_HALF  = 2;
    // Command codes {ras_n, cas_n, we_n}
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_RD  = 3'h5;
    localparam logic [2:0] CMD_WR  = 3'h4;
    localparam logic [2:0] CMD_MRS = 3'h0;
    localparam logic [2:0] CMD_NOP = 3'h7;

    typedef enum logic [1:0] {
        DCPD_MR0,
        DCPD_MR1,
        DCPD_MR2,
        DCPD_MR3
    } dcpd_mr_e;
endpackage

// [hdl/dcpd_if.sv]
`timescale 1ns/1ps
interface dcpd_if;
    logic                        ck;
    logic                        cke;
    logic                        reset_n;
    logic                        cs_n;
    logic                        ras_n;
    logic                        cas_n;
    logic                        we_n;
    logic [dcpd_pkg::BANK_W-1:0] ba;
    logic [dcpd_pkg::ROW_W-1:0]  addr;
    logic                        odt;
    logic [dcpd_pkg::NLANE-1:0]  dm;
    // Two-way data and strobes, one driver set per end
    logic [dcpd_pkg::DQ_W-1:0]   dq_c;
    logic                        dq_c_oe;
    logic [dcpd_pkg::DQ_W-1:0]   dq_d;
    logic                        dq_d_oe;
    logic [dcpd_pkg::NLANE-1:0]  dqs_c;
    logic                        dqs_c_oe;
    logic [dcpd_pkg::NLANE-1:0]  dqs_d;
    logic                        dqs_d_oe;
    logic [dcpd_pkg::DQ_W-1:0]   dq;
    logic [dcpd_pkg::NLANE-1:0]  dqs;
    logic [dcpd_pkg::NLANE-1:0]  dqs_b;

    assign dq    = dq_c_oe ? dq_c : (dq_d_oe ? dq_d : '0);
    assign dqs   = dqs_c_oe ? dqs_c : (dqs_d_oe ? dqs_d : '0);
    assign dqs_b = ~dqs;

    modport ctrl (
        output ck, cke, reset_n, cs_n, ras_n, cas_n, we_n, ba, addr, odt,
        output dm, dq_c, dq_c_oe, dqs_c, dqs_c_oe,
        input  dq, dqs, dqs_b
    );
    modport dev (
        input  ck, cke, reset_n, cs_n, ras_n, cas_n, we_n, ba, addr, odt,
        input  dm, dq, dqs, dqs_b,
        output dq_d, dq_d_oe, dqs_d, dqs_d_oe
    );
endinterface

// [hdl/dcpd_dev.sv]
`timescale 1ns/1ps
// How it works
// RULE1: Row on activate, column on access
// RULE2: Mode set takes op-code from address
// RULE3: A10 high on access auto-precharges bank
// RULE4: Precharge A10 selects one or all banks
// RULE5: A12 low chops burst to four
// RULE6: Chip select high masks all commands
// RULE7: Activate opens bank, precharge idles it
// RULE8: Column access: read or write by WE
// RULE9: Command pins latched on rising clock
// RULE10: Data mask high discards its byte
// RULE11: One strobe per byte lane; the device times both lanes from the lane 0 strobe
// RULE12: Data moves on both strobe edges
// RULE13: Registered termination enables all lines
// RULE14: Termination ignored when mode disables it
// RULE15: Low reset input resets asynchronously; here reset_n is synchronised over two clk_sys stages
// RULE16: Bank address bits pick target bank
// RULE17: Clock enable low freezes internal state; write beats and odt_q still update here
module dcpd_dev #(
    parameter int NWORDS = 16
) (
    // System
    input  wire logic                       clk_sys,
    input  wire logic                       rstn,
    // Link
    dcpd_if.dev                             link,
    // Status
    output logic [dcpd_pkg::NBANK-1:0]      bank_open,
    output logic                            odt_active,
    output logic                            write_strobe,
    output logic [dcpd_pkg::BANK_W-1:0]     write_bank,
    output logic [dcpd_pkg::COL_W-1:0]      write_col,
    output logic [dcpd_pkg::DQ_W-1:0]       write_data,
    output logic [dcpd_pkg::NLANE-1:0]      write_keep
);
    // Index arithmetic wraps, so the depth must be a power of two
    if (NWORDS < 2 || NWORDS > 1024 || (NWORDS & (NWORDS - 1)) != 0)
    begin : g_bad_nwords
        $error("NWORDS out of range");
    end

    localparam int AW        = $clog2(NWORDS);
    localparam int DCPD_IDX1 = 1;

    // Command pins, carried through the same two stages as the link clock
    typedef struct packed {
        logic                        cke;
        logic                        cs_n;
        logic [2:0]                  cmd;
        logic [dcpd_pkg::BANK_W-1:0] ba;
        logic [dcpd_pkg::ROW_W-1:0]  addr;
        logic                        odt;
    } dcpd_pin_s;

    typedef struct packed {
        dcpd_pin_s [1:0]                 pin_s;
        logic [1:0][dcpd_pkg::DQ_W-1:0]  dq_s;
        logic [1:0][dcpd_pkg::NLANE-1:0] dm_s;
        logic [dcpd_pkg::COL_W-1:0]      wcol;
        logic [1:0]                      ck_s;
        logic                            ck_d;
        logic [1:0]                      rst_s;
        logic [1:0]                      dqs_s;
        logic                            dqs_d;
        logic                            cke_q;
        logic [dcpd_pkg::NBANK-1:0]      open;
        logic [dcpd_pkg::NBANK-1:0][dcpd_pkg::ROW_W-1:0] row;
        logic [3:0][dcpd_pkg::ROW_W-1:0] mr;
        logic                            odt_q;
        logic                            rd;
        logic                            wr;
        logic                            ap;
        logic [dcpd_pkg::CNT_W-1:0]      left;
        logic [dcpd_pkg::BANK_W-1:0]     bank;
        logic [dcpd_pkg::COL_W-1:0]      col;
        logic [dcpd_pkg::DQ_W-1:0]       dq_o;
        logic                            dq_oe;
        logic [dcpd_pkg::NLANE-1:0]      dqs_o;
        logic                            wstb;
        logic [dcpd_pkg::DQ_W-1:0]       wdat;
        logic [dcpd_pkg::NLANE-1:0]      wkeep;
        logic [NWORDS-1:0][dcpd_pkg::DQ_W-1:0] mem;
    } dcpd_dev_s;

    dcpd_dev_s st_reg;
    dcpd_dev_s st_next;
    logic      ck_rise;
    logic      dqs_edge;
    dcpd_pin_s  pin;
    logic [2:0] cmd;
    logic [AW-1:0] widx;

    assign ck_rise  = st_reg.ck_s[1] & ~st_reg.ck_d;
    assign dqs_edge = st_reg.dqs_s[1] ^ st_reg.dqs_d;
    assign pin      = st_reg.pin_s[1];
    assign cmd      = pin.cmd;
    assign widx     = AW'(st_reg.col + {st_reg.bank, 1'b0});

    always_comb begin
        st_next          = st_reg;
        st_next.ck_s     = {st_reg.ck_s[0], link.ck};
        st_next.ck_d     = st_reg.ck_s[1];
        st_next.rst_s    = {st_reg.rst_s[0], link.reset_n};
        st_next.dqs_s    = {st_reg.dqs_s[0], link.dqs[0]};
        st_next.dqs_d    = st_reg.dqs_s[1];
        st_next.pin_s    = {st_reg.pin_s[0], link.cke, link.cs_n, link.ras_n,
                            link.cas_n, link.we_n, link.ba, link.addr,
                            link.odt};
        st_next.dq_s     = {st_reg.dq_s[0], link.dq};
        st_next.dm_s     = {st_reg.dm_s[0], link.dm};
        st_next.wstb     = 1'b0;
        // RULE15: pin reset
        if (!st_reg.rst_s[1]) begin
            st_next.open  = '0;
            st_next.rd    = 1'b0;
            st_next.wr    = 1'b0;
            st_next.dq_oe = 1'b0;
            st_next.odt_q = 1'b0;
            st_next.mr    = '0;
        end else if (ck_rise) begin
            // RULE17: clock enable gate
            st_next.cke_q = pin.cke;
            // RULE13: registered termination
            st_next.odt_q = pin.odt;
            // RULE9: latch on clock rise
            // RULE6: chip select mask
            if (st_reg.cke_q && pin.cke && !pin.cs_n) begin
                case (cmd)
                    // RULE7: activate
                    // RULE16: bank select
                    // RULE1: row address
                    dcpd_pkg::CMD_ACT: begin
                        st_next.open[pin.ba] = 1'b1;
                        st_next.row[pin.ba]  = pin.addr;
                    end
                    // RULE4: one or all
                    dcpd_pkg::CMD_PRE: begin
                        if (pin.addr[dcpd_pkg::AP_BIT]) begin
                            st_next.open = '0;
                        end else begin
                            st_next.open[pin.ba] = 1'b0;
                        end
                    end
                    // RULE8: read or write
                    dcpd_pkg::CMD_RD, dcpd_pkg::CMD_WR: begin
                        st_next.rd   = cmd[0];
                        st_next.wr   = ~cmd[0];
                        st_next.bank = pin.ba;
                        // RULE1: column address
                        st_next.col  = pin.addr[dcpd_pkg::COL_W-1:0];
                        // RULE3: auto-precharge flag
                        st_next.ap   = pin.addr[dcpd_pkg::AP_BIT];
                        // RULE5: burst chop
                        st_next.left = pin.addr[dcpd_pkg::BC_BIT]
                            ? dcpd_pkg::CNT_W'(dcpd_pkg::BL_FULL)
                            : dcpd_pkg::CNT_W'(dcpd_pkg::BL_CHOP);
                    end
                    // RULE2: op-code from address
                    dcpd_pkg::CMD_MRS: begin
                        st_next.mr[pin.ba[1:0]] = pin.addr;
                    end
                    default: begin
                    end
                endcase
            end
            // Preamble parks the strobe low so every beat is an edge
            if (st_reg.rd && !st_reg.dq_oe && st_reg.cke_q) begin
                st_next.dq_oe = 1'b1;
                st_next.dqs_o = '0;
            end
        end
        // RULE12: read beat per strobe edge
        if (st_reg.rd && st_reg.dq_oe && st_reg.ck_s[1] != st_reg.ck_d
                && st_reg.cke_q && st_reg.left != '0) begin
            st_next.dqs_o = ~st_reg.dqs_o;
            st_next.dq_o  = st_reg.mem[widx];
            st_next.col   = st_reg.col + 1'b1;
            st_next.left  = st_reg.left - 1'b1;
        end
        // RULE12: write beat per strobe edge
        // RULE11: lane 0 strobe times both lanes, not one strobe per lane
        if (st_reg.wr && dqs_edge && st_reg.left != '0) begin
            st_next.wstb  = 1'b1;
            st_next.wdat  = st_reg.dq_s[1];
            st_next.wcol  = st_reg.col;
            // RULE10: masked bytes
            st_next.wkeep = ~st_reg.dm_s[1];
            for (int i = 0; i < dcpd_pkg::NLANE; i++) begin
                if (!st_reg.dm_s[1][i]) begin
                    st_next.mem[widx][i*dcpd_pkg::LANE_W +: dcpd_pkg::LANE_W]
                        = st_reg.dq_s[1][i*dcpd_pkg::LANE_W
                                         +: dcpd_pkg::LANE_W];
                end
            end
            st_next.col  = st_reg.col + 1'b1;
            st_next.left = st_reg.left - 1'b1;
        end
        if ((st_reg.rd || st_reg.wr) && st_reg.left == '0) begin
            st_next.rd    = 1'b0;
            st_next.wr    = 1'b0;
            st_next.dq_oe = 1'b0;
            // RULE3: close after access
            if (st_reg.ap) begin
                st_next.open[st_reg.bank] = 1'b0;
            end
        end
    end

    // RULE15: asynchronous reset
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign link.dq_d    = st_reg.dq_o;
    assign link.dq_d_oe = st_reg.dq_oe;
    assign link.dqs_d   = {dcpd_pkg::NLANE{st_reg.dqs_o[0]}};
    assign link.dqs_d_oe = st_reg.dq_oe;
    assign bank_open    = st_reg.open;
    // RULE14: mode disables termination
    assign odt_active   = st_reg.odt_q
        && (st_reg.mr[DCPD_IDX1][dcpd_pkg::MR_ODT_HI:dcpd_pkg::MR_ODT_LO]
            != '0);
    assign write_strobe = st_reg.wstb;
    assign write_bank   = st_reg.bank;
    assign write_col    = st_reg.wcol;
    assign write_data   = st_reg.wdat;
    assign write_keep   = st_reg.wkeep;
endmodule

// [hdl/dcpd_ctrl.sv]
`timescale 1ns/1ps
module dcpd_ctrl (
    // System
    input  wire logic                       clk_sys,
    input  wire logic                       rstn,
    // Command request
    input  wire logic                       req_valid,
    output logic                            req_ready,
    input  wire logic [2:0]                 req_cmd,
    input  wire logic [dcpd_pkg::BANK_W-1:0] req_bank,
    input  wire logic [dcpd_pkg::ROW_W-1:0] req_addr,
    input  wire logic [dcpd_pkg::DQ_W-1:0]  req_wdata,
    input  wire logic [dcpd_pkg::NLANE-1:0] req_mask,
    input  wire logic                       req_odt,
    // Read data
    output logic                            rd_valid,
    output logic [dcpd_pkg::DQ_W-1:0]       rd_data,
    // Link
    dcpd_if.ctrl                            link
);
    typedef enum {C_IDLE, C_CMD, C_WDATA} dcpd_st_e;
    typedef struct packed {
        logic [1:0]                      div;
        logic                            ck;
        dcpd_st_e                        st;
        logic [2:0]                      cmd;
        logic [dcpd_pkg::BANK_W-1:0]     ba;
        logic [dcpd_pkg::ROW_W-1:0]      addr;
        logic                            odt;
        logic [dcpd_pkg::DQ_W-1:0]       wd;
        logic [dcpd_pkg::NLANE-1:0]      dm;
        logic                            dqs;
        logic                            doe;
        logic [dcpd_pkg::CNT_W-1:0]      left;
        logic [1:0]                      dqs_s;
        logic                            dqs_d;
        logic                            rv;
        logic [dcpd_pkg::DQ_W-1:0]       rdat;
        logic [1:0]                      doe_s;
        logic                            doe_d;
        logic [1:0][dcpd_pkg::DQ_W-1:0]  dq_s;
    } dcpd_ctrl_s;
    dcpd_ctrl_s s_reg;
    dcpd_ctrl_s s_next;
    logic fall;

    assign fall = s_reg.div == 2'(dcpd_pkg::CK_HALF - 1) && s_reg.ck;

    always_comb begin
        s_next       = s_reg;
        s_next.rv    = 1'b0;
        s_next.dqs_s = {s_reg.dqs_s[0], link.dqs[0]};
        s_next.dqs_d = s_reg.dqs_s[1];
        // Own drive delayed like the strobe, so own edges are not read back
        s_next.doe_s = {s_reg.doe_s[0], s_reg.doe};
        s_next.doe_d = s_reg.doe_s[1];
        s_next.dq_s  = {s_reg.dq_s[0], link.dq};
        s_next.div   = s_reg.div + 1'b1;
        if (s_reg.div == 2'(dcpd_pkg::CK_HALF - 1)) begin
            s_next.div = '0;
            s_next.ck  = ~s_reg.ck;
        end
        // Commands change on the falling half so they are stable at rise
        case (s_reg.st)
            C_IDLE: begin
                if (req_valid && fall) begin
                    s_next.cmd  = req_cmd;
                    s_next.ba   = req_bank;
                    s_next.addr = req_addr;
                    s_next.odt  = req_odt;
                    s_next.wd   = req_wdata;
                    s_next.dm   = req_mask;
                    s_next.st   = C_CMD;
                end
            end
            C_CMD: begin
                if (fall) begin
                    s_next.cmd = dcpd_pkg::CMD_NOP;
                    s_next.st  = C_IDLE;
                    if (s_reg.cmd == dcpd_pkg::CMD_WR) begin
                        s_next.st   = C_WDATA;
                        s_next.doe  = 1'b1;
                        s_next.left = s_reg.addr[dcpd_pkg::BC_BIT]
                            ? dcpd_pkg::CNT_W'(dcpd_pkg::BL_FULL)
                            : dcpd_pkg::CNT_W'(dcpd_pkg::BL_CHOP);
                    end
                end
            end
            C_WDATA: begin
                // Drive is held one half period past the last strobe edge
                if (s_reg.div == '0) begin
                    if (s_reg.left == '0) begin
                        s_next.doe = 1'b0;
                        s_next.st  = C_IDLE;
                    end else begin
                        s_next.dqs  = ~s_reg.dqs;
                        s_next.left = s_reg.left - 1'b1;
                    end
                end
            end
            default: s_next.st = C_IDLE;
        endcase
        if (!(s_reg.doe_s[1] | s_reg.doe_d)
                && (s_reg.dqs_s[1] ^ s_reg.dqs_d)) begin
            s_next.rv   = 1'b1;
            s_next.rdat = s_reg.dq_s[1];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_reg     <= '0;
            s_reg.cmd <= dcpd_pkg::CMD_NOP;
            s_reg.st  <= C_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign req_ready     = s_reg.st == C_IDLE && fall;
    assign link.ck       = s_reg.ck;
    assign link.cke      = 1'b1;
    assign link.reset_n  = rstn;
    assign link.cs_n     = s_reg.st != C_CMD;
    assign link.ras_n    = s_reg.cmd[2];
    assign link.cas_n    = s_reg.cmd[1];
    assign link.we_n     = s_reg.cmd[0];
    assign link.ba       = s_reg.ba;
    assign link.addr     = s_reg.addr;
    assign link.odt      = s_reg.odt;
    assign link.dm       = s_reg.dm;
    assign link.dq_c     = s_reg.wd;
    assign link.dq_c_oe  = s_reg.doe;
    assign link.dqs_c    = {dcpd_pkg::NLANE{s_reg.dqs}};
    assign link.dqs_c_oe = s_reg.doe;
    assign rd_valid      = s_reg.rv;
    assign rd_data       = s_reg.rdat;
endmodule

// [verif/dcpd_properties.sv]
`timescale 1ns/1ps
module dcpd_properties (
    // System
    input wire logic                        clk_sys,
    input wire logic                        rstn,
    // Link
    input wire logic                        ck,
    input wire logic                        reset_n,
    input wire logic                        cs_n,
    input wire logic                        ras_n,
    input wire logic                        cas_n,
    input wire logic                        we_n,
    input wire logic [dcpd_pkg::BANK_W-1:0] ba,
    input wire logic [dcpd_pkg::ROW_W-1:0]  addr,
    input wire logic                        dq_c_oe,
    input wire logic                        dq_d_oe,
    input wire logic [dcpd_pkg::NLANE-1:0]  dqs_c,
    input wire logic                        dqs_c_oe,
    input wire logic                        dqs_d_oe
);
    typedef struct packed {
        logic       ck;
        logic [6:0] rd_age;
        logic [6:0] wr_age;
    } dcpd_chk_s;
    dcpd_chk_s  st_reg;
    dcpd_chk_s  st_next;
    logic [2:0] cmd;
    logic       cmd_edge;
    assign cmd = {ras_n, cas_n, we_n};
    assign cmd_edge = ck && !st_reg.ck && !cs_n;
    // ------------
    // Age since last column command, saturating
    // ------------
    always_comb begin
        st_next = st_reg;
        st_next.ck = ck;
        if (st_reg.rd_age != 7'h7f) st_next.rd_age = st_reg.rd_age + 7'h01;
        if (st_reg.wr_age != 7'h7f) st_next.wr_age = st_reg.wr_age + 7'h01;
        if (cmd_edge && cmd == dcpd_pkg::CMD_RD) st_next.rd_age = 7'h00;
        if (cmd_edge && cmd == dcpd_pkg::CMD_WR) st_next.wr_age = 7'h00;
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '{ck: 1'b0, rd_age: 7'h7f, wr_age: 7'h7f};
        end else begin
            st_reg <= st_next;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    // ------------
    // Properties
    // ------------
    property p_ck_period;
        $rose(ck) |-> ck[*2] ##1 !ck[*2] ##1 ck;
    endproperty
    a_ck_period: assert property (p_ck_period)
        else $error("link clock period wrong");
    property p_cmd_stable;
        ck && $past(ck) |-> $stable({cs_n, cmd, ba, addr});
    endproperty
    a_cmd_stable: assert property (p_cmd_stable)
        else $error("command moved while link clock high");
    property p_dq_excl;
        dq_c_oe |-> !dq_d_oe;
    endproperty
    a_dq_excl: assert property (p_dq_excl)
        else $error("both ends drive data");
    property p_dqs_excl;
        dqs_c_oe |-> !dqs_d_oe;
    endproperty
    a_dqs_excl: assert property (p_dqs_excl)
        else $error("both ends drive strobe");
    property p_lane_pair;
        dqs_c_oe |-> dqs_c[0] == dqs_c[1];
    endproperty
    a_lane_pair: assert property (p_lane_pair)
        else $error("lane strobes differ");
    property p_rd_cause;
        $rose(dq_d_oe) |-> st_reg.rd_age < 7'h40;
    endproperty
    a_rd_cause: assert property (p_rd_cause)
        else $error("device drove data without a read");
    property p_wr_cause;
        $rose(dq_c_oe) |-> st_reg.wr_age < 7'h40;
    endproperty
    a_wr_cause: assert property (p_wr_cause)
        else $error("controller drove data without a write");
    property p_reset_hold;
        $past(rstn, 4) |-> reset_n;
    endproperty
    a_reset_hold: assert property (p_reset_hold)
        else $error("link reset low in normal operation");
endmodule

// [verif/dcpd_tb.sv]
`timescale 1ns/1ps
module dcpd_tb;
    logic                        clk_sys;
    logic                        rstn;
    logic                        req_valid;
    logic                        req_ready;
    logic [2:0]                  req_cmd;
    logic [dcpd_pkg::BANK_W-1:0] req_bank;
    logic [dcpd_pkg::ROW_W-1:0]  req_addr;
    logic [dcpd_pkg::DQ_W-1:0]   req_wdata;
    logic [dcpd_pkg::NLANE-1:0]  req_mask;
    logic                        req_odt;
    logic                        rd_valid;
    logic [dcpd_pkg::DQ_W-1:0]   rd_data;
    logic [dcpd_pkg::NBANK-1:0]  bank_open;
    logic                        odt_active;
    logic                        write_strobe;
    logic [dcpd_pkg::BANK_W-1:0] write_bank;
    logic [dcpd_pkg::COL_W-1:0]  write_col;
    logic [dcpd_pkg::DQ_W-1:0]   write_data;
    logic [dcpd_pkg::NLANE-1:0]  write_keep;
    logic [31:0]                 seed;
    logic [15:0]                 mem [16];
    logic [15:0]                 exp_q [$];
    logic [15:0]                 exp_wd;
    logic [15:0]                 exp_kb;
    logic [15:0]                 exp_wloc;
    logic [7:0]                  open_m;
    logic [2:0]                  mr1;
    logic                        oe_q;
    logic                        dqs_q;
    int n_fail, check_count, beats, last_beats, i, p;

    dcpd_if link ();
    dcpd_ctrl dcpd_ctrl_i (.clk_sys(clk_sys), .rstn(rstn),
        .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd),
        .req_bank(req_bank), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_mask(req_mask), .req_odt(req_odt), .rd_valid(rd_valid),
        .rd_data(rd_data), .link(link));
    dcpd_dev #(.NWORDS(16)) dcpd_dev_i (.clk_sys(clk_sys), .rstn(rstn),
        .link(link), .bank_open(bank_open), .odt_active(odt_active),
        .write_strobe(write_strobe), .write_bank(write_bank),
        .write_col(write_col), .write_data(write_data),
        .write_keep(write_keep));
    dcpd_properties dcpd_properties_i (.clk_sys(clk_sys), .rstn(rstn),
        .ck(link.ck), .reset_n(link.reset_n), .cs_n(link.cs_n),
        .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
        .ba(link.ba), .addr(link.addr), .dq_c_oe(link.dq_c_oe),
        .dq_d_oe(link.dq_d_oe), .dqs_c(link.dqs_c),
        .dqs_c_oe(link.dqs_c_oe), .dqs_d_oe(link.dqs_d_oe));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------
    // One command through the controller, model updated on acceptance
    // ------------
    task automatic op(input logic [2:0] c, input int b, input int a,
                      input logic o, input logic [1:0] m);
        int n;
        int x;
        int bl;
        int k;
        @(posedge clk_sys);
        seed = lfsr(seed);
        req_cmd   <= c;
        req_bank  <= b[2:0];
        req_addr  <= a[14:0];
        req_wdata <= seed[15:0];
        req_mask  <= m;
        req_odt   <= o;
        req_valid <= 1'b1;
        n = 0;
        @(negedge clk_sys);
        while (req_ready !== 1'b1 && n < 200) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 200) n_fail++;
        exp_kb = {{8{~m[1]}}, {8{~m[0]}}};
        bl = a[12] ? 8 : 4;
        if (c == dcpd_pkg::CMD_WR) begin
            exp_wd = seed[15:0];
            exp_wloc = {b[2:0], a[9:0], ~m, 1'b0};
        end
        // Burst walks consecutive words; words live at column plus 2 x bank
        if (c == dcpd_pkg::CMD_WR || c == dcpd_pkg::CMD_RD)
            for (k = 0; k < bl; k++) begin
                x = (a[9:0] + k + 2 * b) % 16;
                if (c == dcpd_pkg::CMD_WR)
                    mem[x] = (mem[x] & ~exp_kb) | (seed[15:0] & exp_kb);
                else
                    exp_q.push_back(mem[x]);
            end
        if (c == dcpd_pkg::CMD_ACT) open_m[b] = 1'b1;
        if (c == dcpd_pkg::CMD_PRE && a[10]) open_m = 8'h00;
        if (c != dcpd_pkg::CMD_ACT && c != dcpd_pkg::CMD_MRS && c !=
            dcpd_pkg::CMD_NOP && !(c == dcpd_pkg::CMD_PRE && a[10]) &&
            (c == dcpd_pkg::CMD_PRE || a[10])) open_m[b] = 1'b0;
        if (c == dcpd_pkg::CMD_MRS && b == int'(dcpd_pkg::DCPD_MR1))
            mr1 = a[2:0];
        last_beats = 0;
        @(posedge clk_sys);
        req_valid <= 1'b0;
        repeat (100) @(posedge clk_sys);
        if (c == dcpd_pkg::CMD_WR || c == dcpd_pkg::CMD_RD)
            chk_flag(8'(last_beats), a[12] ? 8'h08 : 8'h04);
        chk_flag(8'(exp_q.size()), 8'h00);
        chk_flag(bank_open, open_m);
        chk_flag({7'h00, odt_active}, {7'h00, o && mr1 != 3'h0});
    endtask

    // ------------
    // Monitors, sampled mid-cycle where outputs are settled
    // ------------
    always @(negedge clk_sys) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) chk_flag(8'h01, 8'h00);
            else chk_word(rd_data, exp_q.pop_front());
        end
        if (write_strobe === 1'b1) begin
            chk_word(write_data & exp_kb, exp_wd & exp_kb);
            chk_word({write_bank, write_col, write_keep, 1'b0}, exp_wloc);
            exp_wloc = exp_wloc + 16'h0008;
        end
        if ((link.dqs_c_oe | link.dqs_d_oe) && link.dqs[0] !== dqs_q) beats++;
        if (oe_q && !(link.dqs_c_oe | link.dqs_d_oe)) begin
            last_beats = beats;
            beats = 0;
        end
        oe_q = link.dqs_c_oe | link.dqs_d_oe;
        dqs_q = link.dqs[0];
    end

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        #200000;
        n_fail++;
        print_verdict();
    end

    initial begin
        {rstn, req_valid, req_cmd, req_bank, req_addr} = '0;
        {req_wdata, req_mask, req_odt, open_m, mr1} = '0;
        {n_fail, check_count, beats, last_beats, oe_q, dqs_q} = '0;
        seed = 32'h0000_0e98;
        foreach (mem[j]) mem[j] = '0;
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        op(dcpd_pkg::CMD_MRS, 1, 'h0, 1'b1, 2'h0);
        op(dcpd_pkg::CMD_MRS, 1, 'h2, 1'b1, 2'h0);
        op(dcpd_pkg::CMD_NOP, 0, 'h0, 1'b0, 2'h0);
        for (i = 0; i < 8; i++) op(dcpd_pkg::CMD_ACT, i, i * 'h0a35, 0, 0);
        // Second pass masks random bytes over known data
        for (p = 0; p < 2; p++)
            for (i = 0; i < 16; i++)
                op(dcpd_pkg::CMD_WR, i / 2, (i % 2) + p * 'h1000, 0,
                   p ? seed[17:16] : 2'h0);
        for (i = 0; i < 16; i++)
            op(dcpd_pkg::CMD_RD, i / 2, (i % 2) + (i / 4 % 2) * 'h1000,
               0, 0);
        op(dcpd_pkg::CMD_RD, 3, 'h1400, 0, 0);
        op(dcpd_pkg::CMD_WR, 4, 'h0401, 0, 0);
        op(dcpd_pkg::CMD_PRE, 5, 'h0000, 0, 0);
        op(dcpd_pkg::CMD_PRE, 0, 'h0400, 0, 0);
        op(dcpd_pkg::CMD_ACT, 2, 'h7fff, 0, 0);
        rstn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk_flag(bank_open, 8'h00);
        rstn <= 1'b1;
        print_verdict();
    end
endmodule
